// [dcct_pkg.sv]
package dcct_pkg;
  localparam int CW = 16;
  localparam int NCH = 2;
  localparam int CTRL_W = 11;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TC1 = 8'h04;
  localparam logic [7:0] OFF_TC2 = 8'h08;
  localparam logic [7:0] OFF_CNT = 8'h0C;
  localparam logic [7:0] OFF_CAP = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h40;
  localparam logic [7:0] OFF_MASK = 8'h44;
  localparam int CB_RUN = 0;
  localparam int CB_CONT = 1;
  localparam int CB_UP = 2;
  localparam int CB_DIREXT = 3;
  localparam int CB_SRCEXT = 4;
  localparam int CB_BIVAL = 5;
  localparam int CB_CAPEN = 6;
  localparam int CB_GATEEN = 7;
  localparam int CB_TRIGEN = 8;
  localparam int CB_LOAD = 9;
  localparam int CB_CASC = 10;
  localparam logic [10:0] CTRL_KEEP = 11'h5FE;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [15:0] TC_RST = 16'h0000;
  localparam int STAT_W = 4;
  localparam int SB_ZERO = 0;
  localparam int SB_CAPT = 2;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam int TICK_DIV = 4;
  localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
  localparam int PIN_N = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } dcct_state_t;
endpackage

// [dcct_ch_if.sv]
`timescale 1ns/1ns
interface dcct_ch_if;
  logic tick, up, gate, trig, cap;
  logic cont, bival, gate_en, trig_en, cap_en;
  logic start, stop, load;
  logic [15:0] tc1, tc2;
  logic [15:0] cnt, capv;
  logic zero, capev, tout, running;
  modport top (output tick, up, gate, trig, cap, cont, bival, gate_en, trig_en, cap_en,
    start, stop, load, tc1, tc2, input cnt, capv, zero, capev, tout, running);
  modport chan (input tick, up, gate, trig, cap, cont, bival, gate_en, trig_en, cap_en,
    start, stop, load, tc1, tc2, output cnt, capv, zero, capev, tout, running);
endinterface

// [dcct_chan.sv]
`timescale 1ns/1ns
module dcct_chan (
  input wire logic aclk,
  input wire logic aresetn,
  dcct_ch_if.chan ch
);
  dcct_pkg::dcct_state_t state_reg;
  logic sel_reg;
  logic [15:0] cnt_reg, cap_reg;
  logic tout_reg, zero_reg, capev_reg;
  logic counting, hit, reload;
  logic [15:0] step_val, tc_sel;

  // Gate low lets ticks through; with trigger this applies only after RUN
  assign counting = (state_reg == dcct_pkg::ST_RUN) && ch.tick && !(ch.gate_en && ch.gate); // see R11 see R13
  assign step_val = ch.up ? cnt_reg + 16'h0001 : cnt_reg - 16'h0001; // see R5
  assign reload = counting && (cnt_reg == 16'h0000);
  assign hit = counting && (cnt_reg != 16'h0000) && (step_val == 16'h0000);
  assign tc_sel = sel_reg ? ch.tc2 : ch.tc1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= dcct_pkg::ST_IDLE;
    end else if (ch.stop) begin
      state_reg <= dcct_pkg::ST_IDLE; // see R15
    end else if (ch.start) begin
      state_reg <= ch.trig_en ? dcct_pkg::ST_WAIT : dcct_pkg::ST_RUN; // see R12
    end else begin
      unique case (state_reg)
        dcct_pkg::ST_IDLE: begin
        end
        dcct_pkg::ST_WAIT: begin
          if (ch.trig) begin
            state_reg <= dcct_pkg::ST_RUN; // see R12
          end
        end
        dcct_pkg::ST_RUN: begin
          if (hit && !ch.cont) begin
            state_reg <= dcct_pkg::ST_IDLE; // see R6 see R14
          end
        end
        default: state_reg <= dcct_pkg::ST_IDLE;
      endcase
    end
  end

  // A zero count reloads on the next tick, so every down-count period is the constant plus one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= dcct_pkg::TC_RST;
      sel_reg <= 1'b0;
    end else if (ch.load) begin
      cnt_reg <= ch.tc1;
      sel_reg <= ch.bival;
    end else if (reload) begin
      cnt_reg <= tc_sel; // see R7 see R14
      sel_reg <= ch.bival ? !sel_reg : 1'b0;
    end else if (counting) begin
      cnt_reg <= step_val; // see R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_reg <= 1'b0;
      tout_reg <= 1'b0;
    end else begin
      zero_reg <= hit; // see R10
      tout_reg <= tout_reg ^ hit; // see R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_reg <= dcct_pkg::TC_RST;
      capev_reg <= 1'b0;
    end else begin
      capev_reg <= ch.cap && ch.cap_en;
      if (ch.cap && ch.cap_en) begin
        cap_reg <= cnt_reg; // see R9
      end
    end
  end

  assign ch.cnt = cnt_reg;
  assign ch.capv = cap_reg;
  assign ch.zero = zero_reg;
  assign ch.capev = capev_reg;
  assign ch.tout = tout_reg;
  assign ch.running = state_reg != dcct_pkg::ST_IDLE;

  AST_SINGLE_STOP: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
    (hit && !ch.cont && !ch.start) |=> (state_reg == dcct_pkg::ST_IDLE) && zero_reg)
    else $error("single cycle did not stop at zero");
  AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
    (reload && !ch.load) |=> cnt_reg == $past(tc_sel))
    else $error("zero count not reloaded from selected constant");
  AST_BIVAL_ALT: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
    (reload && ch.bival && !ch.load) |=> sel_reg != $past(sel_reg))
    else $error("bi-value constants did not alternate");
  AST_GATE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // see R11
    (ch.gate_en && ch.gate && !ch.load) |=> $stable(cnt_reg))
    else $error("count moved while gate high");
  AST_TRIG_WAIT: assert property (@(posedge aclk) disable iff (!aresetn) // see R12
    (state_reg == dcct_pkg::ST_WAIT && !ch.trig && !ch.stop && !ch.start) |=> state_reg == dcct_pkg::ST_WAIT)
    else $error("left trigger wait without trigger");
  AST_TOUT: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
    hit |=> tout_reg != $past(tout_reg))
    else $error("output did not toggle at zero");
  AST_CAPT: assert property (@(posedge aclk) disable iff (!aresetn) // see R9
    (ch.cap && ch.cap_en) |=> capev_reg && cap_reg == $past(cnt_reg))
    else $error("capture value wrong");
endmodule // dcct_chan

// [dcct_top.sv]
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
// Operation
// R1: Two independent programmable 16-bit counter/timers
// R2: Cascade joins both into one 32-bit counter
// R3: Internal tick is clock divided by four
// R4: External event input may drive counting
// R5: Up/down by software bit or pin
// R6: Single-cycle or continuous run mode
// R7: Bi-value mode alternates two reload constants
// R8: Output toggles, duty set by constants
// R9: Capture latches count on external event
// R10: Interrupt request whenever count reaches zero
// R11: Gate option counts only while gate low
// R12: Trigger option waits for high pulse
// R13: Gate plus trigger: trigger then gate
// R14: Continuous reloads at zero, single stops
// R15: Software loads, starts, stops, reads count
module dcct_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [1:0] evt_cnt_in,
  input wire logic [1:0] evt_dir_in,
  input wire logic [1:0] gate_in,
  input wire logic [1:0] trig_in,
  input wire logic [1:0] capt_in,
  output logic [1:0] tout,
  output logic irq
);
  localparam int PW = dcct_pkg::PIN_N * dcct_pkg::NCH;

  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [10:0] ctrl_reg [2];
  logic [15:0] tc1_reg [2];
  logic [15:0] tc2_reg [2];
  logic [1:0] start_reg, stop_reg, load_reg;
  logic [3:0] stat_reg, mask_reg;
  logic irq_reg;
  logic [1:0] tout_reg;
  logic [1:0] tick_cnt_reg;
  logic tick4_reg;
  logic [PW-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [PW-1:0] pin_rise;
  logic [15:0] cnt_w [2];
  logic [15:0] capv_w [2];
  logic [1:0] zero_w, capev_w, tout_w, run_w, tick_w;
  logic wr_en, rd_en, w_ok, r_ok;
  logic [7:0] w_off, r_off;
  logic [31:0] ctrl_wm [2];
  logic [31:0] tc1_wm [2];
  logic [31:0] tc2_wm [2];
  logic [31:0] rd_val;
  logic [3:0] stat_clr, ev_w;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Pins: two flops, then a third stage for edge detect off the clean copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= {capt_in, trig_in, gate_in, evt_dir_in, evt_cnt_in};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  assign pin_rise = pin_s2_reg & ~pin_s3_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 2'h0;
      tick4_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 2'h1;
      tick4_reg <= tick_cnt_reg == dcct_pkg::TICK_LAST; // see R3
    end
  end

  // AXI4-Lite write: both channels must be offered before the word is taken
  assign w_off = {3'h0, awaddr[4:0]};
  assign r_off = {3'h0, araddr[4:0]};
  assign wr_en = awready_reg && awvalid && wvalid;
  assign rd_en = arready_reg && arvalid;
  assign w_ok = (awaddr[7:6] == 2'h0) ? (w_off inside {dcct_pkg::OFF_CTRL, dcct_pkg::OFF_TC1,
    dcct_pkg::OFF_TC2, dcct_pkg::OFF_CNT, dcct_pkg::OFF_CAP})
    : (awaddr == dcct_pkg::OFF_STAT || awaddr == dcct_pkg::OFF_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dcct_pkg::RESP_OKAY;
    end else begin
      awready_reg <= awvalid && wvalid && !awready_reg && !bvalid_reg;
      wready_reg <= awvalid && wvalid && !awready_reg && !bvalid_reg;
      if (wr_en) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= w_ok ? dcct_pkg::RESP_OKAY : dcct_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ctrl_wm[i] = merge({21'h0, ctrl_reg[i]}, wdata, wstrb);
      tc1_wm[i] = merge({16'h0, tc1_reg[i]}, wdata, wstrb);
      tc2_wm[i] = merge({16'h0, tc2_reg[i]}, wdata, wstrb);
    end
  end

  // Any CTRL write with RUN clear also stops the channel
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (!aresetn) begin
        ctrl_reg[i] <= dcct_pkg::CTRL_RST;
        tc1_reg[i] <= dcct_pkg::TC_RST;
        tc2_reg[i] <= dcct_pkg::TC_RST;
        start_reg[i] <= 1'b0;
        stop_reg[i] <= 1'b0;
        load_reg[i] <= 1'b0;
      end else begin
        start_reg[i] <= 1'b0;
        stop_reg[i] <= 1'b0;
        load_reg[i] <= 1'b0;
        if (wr_en && awaddr[7:6] == 2'h0 && awaddr[5] == 1'(i)) begin
          if (w_off == dcct_pkg::OFF_CTRL) begin
            ctrl_reg[i] <= ctrl_wm[i][10:0] & dcct_pkg::CTRL_KEEP;
            start_reg[i] <= ctrl_wm[i][dcct_pkg::CB_RUN]; // see R15
            stop_reg[i] <= !ctrl_wm[i][dcct_pkg::CB_RUN]; // see R15
            load_reg[i] <= ctrl_wm[i][dcct_pkg::CB_LOAD]; // see R15
          end
          if (w_off == dcct_pkg::OFF_TC1) begin
            tc1_reg[i] <= tc1_wm[i][15:0];
          end
          if (w_off == dcct_pkg::OFF_TC2) begin
            tc2_reg[i] <= tc2_wm[i][15:0];
          end
        end
      end
    end
  end

  // Read side
  always_comb begin
    rd_val = 32'h0000_0000;
    r_ok = 1'b1;
    if (araddr[7:6] == 2'h0) begin
      case (r_off)
        dcct_pkg::OFF_CTRL: rd_val = {21'h0, ctrl_reg[araddr[5]][10:1], run_w[araddr[5]]};
        dcct_pkg::OFF_TC1: rd_val = {16'h0, tc1_reg[araddr[5]]};
        dcct_pkg::OFF_TC2: rd_val = {16'h0, tc2_reg[araddr[5]]};
        dcct_pkg::OFF_CNT: rd_val = {16'h0, cnt_w[araddr[5]]}; // see R15
        dcct_pkg::OFF_CAP: rd_val = {16'h0, capv_w[araddr[5]]}; // see R9
        default: r_ok = 1'b0;
      endcase
    end else if (araddr == dcct_pkg::OFF_STAT) begin
      rd_val = {28'h0, stat_reg};
    end else if (araddr == dcct_pkg::OFF_MASK) begin
      rd_val = {28'h0, mask_reg};
    end else begin
      r_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= dcct_pkg::RESP_OKAY;
    end else begin
      arready_reg <= arvalid && !arready_reg && !rvalid_reg;
      if (rd_en) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_val;
        rresp_reg <= r_ok ? dcct_pkg::RESP_OKAY : dcct_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Interrupts: a new event in the clearing cycle stays set
  assign ev_w = {capev_w, zero_w};
  assign stat_clr = (wr_en && awaddr == dcct_pkg::OFF_STAT && wstrb[0]) ? wdata[3:0] : 4'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 4'h0;
      mask_reg <= dcct_pkg::MASK_RST;
      irq_reg <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | ev_w; // see R10
      if (wr_en && awaddr == dcct_pkg::OFF_MASK && wstrb[0]) begin
        mask_reg <= wdata[3:0];
      end
      irq_reg <= |(stat_reg & mask_reg); // see R10
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tout_reg <= 2'h0;
    end else begin
      tout_reg <= tout_w;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      dcct_ch_if cif ();
      logic own_tick;
      // Channel 1 takes ch0 zero crossings as its tick when cascaded
      assign own_tick = ctrl_reg[gi][dcct_pkg::CB_SRCEXT] ? pin_rise[gi] : tick4_reg; // see R3 see R4
      if (gi == 1) begin : g_casc
        assign tick_w[gi] = ctrl_reg[0][dcct_pkg::CB_CASC] ? zero_w[0] : own_tick; // see R2
      end else begin : g_solo
        assign tick_w[gi] = own_tick;
      end
      assign cif.tick = tick_w[gi];
      assign cif.up = ctrl_reg[gi][dcct_pkg::CB_DIREXT] ? pin_s2_reg[2+gi] : ctrl_reg[gi][dcct_pkg::CB_UP]; // see R5
      assign cif.gate = pin_s2_reg[4+gi]; // see R11
      assign cif.trig = pin_rise[6+gi]; // see R12
      assign cif.cap = pin_rise[8+gi]; // see R9
      assign cif.cont = ctrl_reg[gi][dcct_pkg::CB_CONT]; // see R6
      assign cif.bival = ctrl_reg[gi][dcct_pkg::CB_BIVAL];
      assign cif.gate_en = ctrl_reg[gi][dcct_pkg::CB_GATEEN];
      assign cif.trig_en = ctrl_reg[gi][dcct_pkg::CB_TRIGEN];
      assign cif.cap_en = ctrl_reg[gi][dcct_pkg::CB_CAPEN];
      assign cif.start = start_reg[gi];
      assign cif.stop = stop_reg[gi];
      assign cif.load = load_reg[gi];
      assign cif.tc1 = tc1_reg[gi];
      assign cif.tc2 = tc2_reg[gi];
      assign cnt_w[gi] = cif.cnt;
      assign capv_w[gi] = cif.capv;
      assign zero_w[gi] = cif.zero;
      assign capev_w[gi] = cif.capev;
      assign tout_w[gi] = cif.tout;
      assign run_w[gi] = cif.running;
      dcct_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .ch(cif.chan)
      );
    end
  endgenerate

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign irq = irq_reg;
  assign tout = tout_reg;

  AST_PRESC: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
    tick4_reg |=> !tick4_reg [*3] ##1 tick4_reg)
    else $error("internal tick not every fourth cycle");
  AST_CASC: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
    (ctrl_reg[0][dcct_pkg::CB_CASC] && zero_w[0]) |-> tick_w[1])
    else $error("cascade carry lost");
  AST_ZERO_IRQ: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
    (zero_w[0] && mask_reg[dcct_pkg::SB_ZERO]) |=> stat_reg[dcct_pkg::SB_ZERO] ##1 irq_reg)
    else $error("zero event did not raise interrupt");
endmodule // dcct_top

// [dcct_ext_model.sv]
`timescale 1ns/1ns
module dcct_ext_model (
  input wire logic aclk,
  output logic [1:0] evt_cnt_in,
  output logic [1:0] evt_dir_in,
  output logic [1:0] gate_in,
  output logic [1:0] trig_in,
  output logic [1:0] capt_in
);
  initial begin
    evt_cnt_in = 2'h0;
    evt_dir_in = 2'h3;
    gate_in = 2'h0;
    trig_in = 2'h0;
    capt_in = 2'h0;
  end

  // Kind 0 event, 1 trigger, 2 capture; 3 cycles high and low so the synchroniser never misses one
  task automatic pulse(input int kind, input int ch, input int n);
    logic [1:0] m;
    m = 2'(1 << ch);
    repeat (n) begin
      @(posedge aclk);
      case (kind)
        0: evt_cnt_in <= evt_cnt_in | m;
        1: trig_in <= trig_in | m;
        default: capt_in <= capt_in | m;
      endcase
      repeat (3) @(posedge aclk);
      evt_cnt_in <= evt_cnt_in & ~m;
      trig_in <= trig_in & ~m;
      capt_in <= capt_in & ~m;
      repeat (3) @(posedge aclk);
    end
  endtask

  task automatic level(input logic [1:0] g, input logic [1:0] d);
    @(posedge aclk);
    gate_in <= g;
    evt_dir_in <= d;
  endtask
endmodule // dcct_ext_model

// [dual_cascadable_counter_timer_bench.sv]
`timescale 1ns/1ns
module dual_cascadable_counter_timer_bench;
  localparam logic [31:0] RUN = 32'h1, CONT = 32'h2, UP = 32'h4, DIREXT = 32'h8, SRCEXT = 32'h10,
    BIVAL = 32'h20, CAPEN = 32'h40, GATEEN = 32'h80, TRIGEN = 32'h100, LOAD = 32'h200, CASC = 32'h400;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, tout, evt_cnt_in, evt_dir_in, gate_in, trig_in, capt_in;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int error_cnt = 0;
  int n_tests = 0;
  int seed;
  int n1, n2, tc;

  always #10 aclk = ~aclk;

  dcct_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .evt_cnt_in(evt_cnt_in), .evt_dir_in(evt_dir_in), .gate_in(gate_in),
    .trig_in(trig_in), .capt_in(capt_in), .tout(tout), .irq(irq));

  dcct_ext_model ext (.aclk(aclk), .evt_cnt_in(evt_cnt_in), .evt_dir_in(evt_dir_in), .gate_in(gate_in),
    .trig_in(trig_in), .capt_in(capt_in));

  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // Both write channels offered together; the slave takes them in one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = dcct_pkg::RESP_OKAY);
    bq.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = dcct_pkg::RESP_OKAY);
    rq.push_back({e, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Cycles until tout of a channel next changes, bounded
  task automatic tog(input int ch, output int n);
    logic v;
    n = 0;
    v = tout[ch];
    while (tout[ch] === v && n < 300) begin
      @(posedge aclk);
      n++;
    end
  endtask

  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1)
      chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    conclude;
  end

  initial begin
    seed = 32'h6B3A;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    rd(8'h18, 32'h0, dcct_pkg::RESP_SLVERR);
    wr(8'h18, 32'h1, dcct_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(8'h04, 32'h3);
    wr(8'h00, LOAD | RUN);
    repeat (40) @(posedge aclk);
    rd(8'h0C, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h1);
    chk("irq masked", 34'h0, {33'h0, irq});
    wr(8'h44, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq raised", 34'h1, {33'h0, irq});
    wr(8'h40, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 34'h0, {33'h0, irq});
    rd(8'h40, 32'h0);
    $display("test single done");
    // Random reloads keep the period short so the run stays brief
    repeat (2) begin
      tc = 1 + ($random(seed) & 3);
      wr(8'h04, 32'(tc));
      wr(8'h00, CONT | LOAD | RUN);
      // A zero from the old period may still be in flight, so skip two edges
      tog(0, n1);
      tog(0, n1);
      tog(0, n1);
      chk("period", 34'((tc + 1) * 4), 34'(n1));
    end
    $display("test continuous done");
    wr(8'h04, 32'h1);
    wr(8'h08, 32'h3);
    wr(8'h00, CONT | BIVAL | LOAD | RUN);
    tog(0, n1);
    tog(0, n1);
    tog(0, n1);
    tog(0, n2);
    chk("bival sum", 34'd24, 34'(n1 + n2));
    chk("bival short", 34'd8, 34'(n1 < n2 ? n1 : n2));
    wr(8'h00, 32'h0);
    wr(8'h40, 32'hF);
    $display("test bivalue done");
    wr(8'h24, 32'hA);
    wr(8'h20, SRCEXT | UP | CAPEN | GATEEN | LOAD | RUN);
    ext.pulse(0, 1, 5);
    rd(8'h2C, 32'hF);
    ext.level(2'h2, 2'h3);
    ext.pulse(0, 1, 3);
    rd(8'h2C, 32'hF);
    ext.level(2'h0, 2'h1);
    wr(8'h20, SRCEXT | DIREXT | CAPEN | RUN);
    ext.pulse(0, 1, 2);
    rd(8'h2C, 32'hD);
    ext.pulse(2, 1, 1);
    repeat (5) @(posedge aclk);
    rd(8'h30, 32'hD);
    rd(8'h40, 32'h8);
    $display("test external done");
    ext.level(2'h0, 2'h3);
    wr(8'h20, TRIGEN | SRCEXT | UP | LOAD | RUN);
    ext.pulse(0, 1, 3);
    rd(8'h2C, 32'hA);
    ext.pulse(1, 1, 1);
    ext.pulse(0, 1, 2);
    rd(8'h2C, 32'hC);
    wr(8'h20, TRIGEN | GATEEN | SRCEXT | UP | LOAD | RUN);
    ext.level(2'h2, 2'h3);
    ext.pulse(1, 1, 1);
    ext.pulse(0, 1, 2);
    rd(8'h2C, 32'hA);
    ext.level(2'h0, 2'h3);
    ext.pulse(0, 1, 2);
    rd(8'h2C, 32'hC);
    $display("test trigger done");
    // Channel 1 counts channel 0 zero crossings; its period spans both constants
    wr(8'h20, CONT | LOAD | RUN);
    wr(8'h00, CASC | CONT | LOAD | RUN);
    tog(1, n1);
    tog(1, n1);
    tog(1, n1);
    chk("cascade period", 34'((10 + 1) * (1 + 1) * dcct_pkg::TICK_DIV), 34'(n1));
    $display("test cascade done");
    repeat (5) @(posedge aclk);
    conclude;
  end
endmodule // dual_cascadable_counter_timer_bench
